// ===== logic/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// Bit positions in power_control_reg_a
`define PMC_PCA_IDLE_BIT      0
`define PMC_PCA_STOP_BIT      1
// Bit positions in power_control_reg_b
`define PMC_PCB_SUSPEND_BIT   0
`define PMC_PCB_SNOOZE_BIT    1
// Bit position of shutdown_select_bit in regulator_control_reg
`define PMC_REG_SHDN_SEL_BIT  0
// Reset values
`define PMC_PCA_RST           8'h00
`define PMC_PCB_RST           8'h00
`define PMC_REG_RST           8'h00
`define PMC_PERIPH_RST        8'h00
`define PMC_ANALOG_RST        4'h0
`define PMC_ON_RST            1'h1
`define PMC_OFF_RST           1'h0
`define PMC_PIN_SYNC_RST      2'h3
`define PMC_CMP_SYNC_RST      2'h0

`endif

// ===== logic/pmc_pkg.sv
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_NORMAL,
        PMC_IDLE,
        PMC_SUSPEND,
        PMC_SNOOZE,
        PMC_STOP,
        PMC_SHUTDOWN
    } pmc_mode_t;
    typedef logic [7:0] pmc_byte_t;
endpackage : pmc_pkg

// ===== logic/pmc_power_mode_controller.sv
// What this block does
// RULE1 - Gate clocks off to every digital peripheral not enabled for use.
// RULE2 - Software may disable each analog peripheral into a low-power state.
// RULE3 - Idle bit halts core, keeps peripherals clocked, any interrupt wakes.
// RULE4 - Waking from Idle, Suspend or Snooze resumes code, no restart.
// RULE5 - Software switches system clock to fast oscillator A before Suspend or Snooze.
// RULE6 - Suspend bit halts core and peripheral clocks, regulators at normal bias.
// RULE7 - Regulator bias stays normal during Suspend for fast wake.
// RULE8 - Snooze bit halts core and peripheral clocks just like Suspend.
// RULE9 - Snooze puts regulators into low bias current operation.
// RULE10 - Both fast oscillators stop in Suspend and Snooze.
// RULE11 - Timers three and four keep running from slow oscillator in Suspend/Snooze.
// RULE12 - Timer four, serial unit, two-wire slave, port match, comparator fall wake.
// RULE13 - Serial unit keeps working asleep and wakes core on a whole byte.
// RULE14 - Stop: select bit clear then stop bit; all internal power nets off.
// RULE15 - Stop is left only through reset; any reset source ends it.
// RULE16 - Shutdown: select bit set then stop bit; core regulator also off.
// RULE17 - Shutdown ends only on external reset pin or power-on reset.
// RULE18 - Stop/Shutdown keep 5 V regulator if enabled and hold pin states.
// RULE19 - Hardware clears Idle, Suspend and Snooze request bits on wake.
`include "pmc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pmc_power_mode_controller (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              por_reset,
    input  wire logic              external_reset_pin_n,
    input  wire logic              other_reset,
    input  wire logic              pca_wr,
    input  wire pmc_pkg::pmc_byte_t pca_wdata,
    input  wire logic              pcb_wr,
    input  wire pmc_pkg::pmc_byte_t pcb_wdata,
    input  wire logic              reg_wr,
    input  wire pmc_pkg::pmc_byte_t reg_wdata,
    input  wire pmc_pkg::pmc_byte_t periph_enable,
    input  wire logic [3:0]        analog_enable,
    input  wire logic              vreg5_enable,
    input  wire logic              any_interrupt,
    input  wire logic              timer4_event,
    input  wire logic              ssu_byte_received,
    input  wire logic              two_wire_slave_activity,
    input  wire logic              port_match_event,
    input  wire logic              comparator0_out,
    output var  pmc_pkg::pmc_byte_t power_control_reg_a,
    output var  pmc_pkg::pmc_byte_t power_control_reg_b,
    output var  pmc_pkg::pmc_byte_t regulator_control_reg,
    output var  pmc_pkg::pmc_mode_t mode,
    output logic                   core_clock_en,
    output pmc_pkg::pmc_byte_t     periph_clock_en,
    output logic                   timer34_slow_clock_en,
    output logic                   ssu_clock_en,
    output logic [3:0]             analog_on,
    output logic                   fast_oscillator_a_en,
    output logic                   fast_oscillator_b_en,
    output logic                   regulator_low_bias,
    output logic                   core_regulator_en,
    output logic                   vreg5_on,
    output logic                   internal_power_en,
    output logic                   pin_hold,
    output logic                   wake_pulse
);
    import pmc_pkg::*;

    pmc_mode_t mode_ff;
    pmc_byte_t pca_ff;
    pmc_byte_t pcb_ff;
    pmc_byte_t reg_ff;
    pmc_byte_t periph_ff;
    logic [3:0] analog_ff;
    logic       vreg5_ff;
    logic       wake_ff;
    logic [1:0] pin_sync_ff;
    logic [1:0] cmp_sync_ff;
    logic       cmp_prev_ff;
    logic       deep_wake;
    logic       sleep_wake;
    logic       any_reset;
    logic       cmp_fall;
    pmc_mode_t  nxt_mode;
    pmc_byte_t  nxt_periph;
    logic [3:0] nxt_analog;
    logic       nxt_vreg5;
    logic       nxt_awake;
    logic       nxt_light;
    logic       nxt_deep;
    logic       core_clk_ff;
    pmc_byte_t  periph_clk_ff;
    logic       slow_clk_ff;
    logic       ssu_clk_ff;
    logic [3:0] analog_on_ff;
    logic       fast_a_ff;
    logic       fast_b_ff;
    logic       low_bias_ff;
    logic       core_reg_ff;
    logic       power_ff;
    logic       hold_ff;

    // Pin inputs cross two flip-flops before use
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_sync_ff <= `PMC_PIN_SYNC_RST;
            cmp_sync_ff <= `PMC_CMP_SYNC_RST;
            cmp_prev_ff <= `PMC_OFF_RST;
        end else begin
            pin_sync_ff <= {pin_sync_ff[0], external_reset_pin_n};
            cmp_sync_ff <= {cmp_sync_ff[0], comparator0_out};
            cmp_prev_ff <= cmp_sync_ff[1];
        end
    end

    assign cmp_fall = cmp_prev_ff & ~cmp_sync_ff[1];

    // RULE12 sleep wake sources
    // RULE13 byte received wakes core
    assign sleep_wake = timer4_event | ssu_byte_received | two_wire_slave_activity |
                        port_match_event | cmp_fall;
    // RULE17 pin or power-on only
    assign deep_wake  = por_reset | ~pin_sync_ff[1];
    // RULE15 any reset source ends Stop
    assign any_reset  = deep_wake | other_reset;

    // Mode sequencing; a wake from a light sleep only drops back to Normal
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            PMC_NORMAL: begin
                if (pca_wr && pca_wdata[`PMC_PCA_STOP_BIT]) begin
                    // RULE14 select clear gives Stop
                    // RULE16 select set gives Shutdown
                    nxt_mode = reg_ff[`PMC_REG_SHDN_SEL_BIT] ? PMC_SHUTDOWN : PMC_STOP;
                end else if (pca_wr && pca_wdata[`PMC_PCA_IDLE_BIT]) begin
                    // RULE3 enter Idle
                    nxt_mode = PMC_IDLE;
                end else if (pcb_wr && pcb_wdata[`PMC_PCB_SUSPEND_BIT]) begin
                    // RULE6 enter Suspend
                    nxt_mode = PMC_SUSPEND;
                end else if (pcb_wr && pcb_wdata[`PMC_PCB_SNOOZE_BIT]) begin
                    // RULE8 enter Snooze
                    nxt_mode = PMC_SNOOZE;
                end
            end
            PMC_IDLE: begin
                // RULE4 resume from halt point
                if (any_interrupt) begin
                    nxt_mode = PMC_NORMAL;
                end
            end
            PMC_SUSPEND, PMC_SNOOZE: begin
                // RULE4 resume from halt point
                if (sleep_wake) begin
                    nxt_mode = PMC_NORMAL;
                end
            end
            PMC_STOP: begin
                if (any_reset) begin
                    nxt_mode = PMC_NORMAL;
                end
            end
            PMC_SHUTDOWN: begin
                if (deep_wake) begin
                    nxt_mode = PMC_NORMAL;
                end
            end
            default: nxt_mode = PMC_NORMAL;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_ff <= PMC_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Power control register A; the wake clear beats a same-cycle write
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pca_ff <= `PMC_PCA_RST;
        end else if (nxt_mode == PMC_NORMAL && mode_ff != PMC_NORMAL) begin
            // RULE19 self-clear on wake
            pca_ff <= `PMC_PCA_RST;
        end else if (pca_wr && mode_ff == PMC_NORMAL) begin
            pca_ff <= pca_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pcb_ff <= `PMC_PCB_RST;
        end else if (nxt_mode == PMC_NORMAL && mode_ff != PMC_NORMAL) begin
            // RULE19 self-clear on wake
            pcb_ff <= `PMC_PCB_RST;
        end else if (pcb_wr && mode_ff == PMC_NORMAL) begin
            pcb_ff <= pcb_wdata;
        end
    end

    // Select bit lives in retained logic, so deep sleep keeps it
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_ff <= `PMC_REG_RST;
        end else if (reg_wr && mode_ff == PMC_NORMAL) begin
            reg_ff <= reg_wdata;
        end
    end

    // Enables follow their inputs only in Normal, so settings hold in Idle and in any sleep
    always_comb begin
        nxt_periph = periph_ff;
        nxt_analog = analog_ff;
        nxt_vreg5  = vreg5_ff;
        if (mode_ff == PMC_NORMAL) begin
            nxt_periph = periph_enable;
            nxt_analog = analog_enable;
            nxt_vreg5  = vreg5_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            periph_ff <= `PMC_PERIPH_RST;
            analog_ff <= `PMC_ANALOG_RST;
            vreg5_ff  <= `PMC_OFF_RST;
        end else begin
            periph_ff <= nxt_periph;
            analog_ff <= nxt_analog;
            vreg5_ff  <= nxt_vreg5;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wake_ff <= `PMC_OFF_RST;
        end else begin
            wake_ff <= (nxt_mode == PMC_NORMAL) && (mode_ff != PMC_NORMAL);
        end
    end

    assign power_control_reg_a   = pca_ff;
    assign power_control_reg_b   = pcb_ff;
    assign regulator_control_reg = reg_ff;
    assign mode                  = mode_ff;
    assign wake_pulse            = wake_ff;

    // Outputs decode the next mode and are registered, so they change on the same edge as mode
    assign nxt_awake = (nxt_mode == PMC_NORMAL) || (nxt_mode == PMC_IDLE);
    assign nxt_light = (nxt_mode == PMC_SUSPEND) || (nxt_mode == PMC_SNOOZE);
    assign nxt_deep  = (nxt_mode == PMC_STOP) || (nxt_mode == PMC_SHUTDOWN);

    // RULE3 core halted in Idle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            core_clk_ff <= `PMC_ON_RST;
        end else begin
            core_clk_ff <= (nxt_mode == PMC_NORMAL);
        end
    end

    // RULE1 gate unused peripherals
    // RULE6 peripheral clocks halted
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            periph_clk_ff <= `PMC_PERIPH_RST;
        end else if (nxt_awake) begin
            periph_clk_ff <= nxt_periph;
        end else begin
            periph_clk_ff <= 8'h00;
        end
    end

    // RULE11 slow clock to timers
    // RULE13 serial unit stays alive
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            slow_clk_ff <= `PMC_ON_RST;
            ssu_clk_ff  <= `PMC_ON_RST;
        end else begin
            slow_clk_ff <= ~nxt_deep;
            ssu_clk_ff  <= ~nxt_deep;
        end
    end

    // RULE2 analog off by software
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            analog_on_ff <= `PMC_ANALOG_RST;
        end else if (nxt_deep) begin
            analog_on_ff <= 4'h0;
        end else begin
            analog_on_ff <= nxt_analog;
        end
    end

    // RULE10 fast oscillators stopped
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fast_a_ff <= `PMC_ON_RST;
            fast_b_ff <= `PMC_ON_RST;
        end else begin
            fast_a_ff <= ~(nxt_light | nxt_deep);
            fast_b_ff <= ~(nxt_light | nxt_deep);
        end
    end

    // Suspend keeps normal bias, trading sleep current for a quick wake
    // RULE7 normal bias in Suspend
    // RULE9 low bias in Snooze
    // RULE16 core regulator off
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            low_bias_ff <= `PMC_OFF_RST;
            core_reg_ff <= `PMC_ON_RST;
        end else begin
            low_bias_ff <= (nxt_mode == PMC_SNOOZE);
            core_reg_ff <= (nxt_mode != PMC_SHUTDOWN);
        end
    end

    // RULE14 internal power nets off
    // RULE18 hold pins and 5 V rail
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            power_ff <= `PMC_ON_RST;
            hold_ff  <= `PMC_OFF_RST;
        end else begin
            power_ff <= ~nxt_deep;
            hold_ff  <= nxt_deep;
        end
    end

    assign core_clock_en         = core_clk_ff;
    assign periph_clock_en       = periph_clk_ff;
    assign timer34_slow_clock_en = slow_clk_ff;
    assign ssu_clock_en          = ssu_clk_ff;
    assign analog_on             = analog_on_ff;
    assign fast_oscillator_a_en  = fast_a_ff;
    assign fast_oscillator_b_en  = fast_b_ff;
    assign regulator_low_bias    = low_bias_ff;
    assign core_regulator_en     = core_reg_ff;
    assign internal_power_en     = power_ff;
    assign pin_hold              = hold_ff;
    assign vreg5_on              = vreg5_ff;

endmodule : pmc_power_mode_controller

`default_nettype wire

// ===== test/pmc_power_mode_controller_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_controller_checker
    import pmc_pkg::*;
(
    input wire logic      clock,
    input wire logic      rst_b,
    input wire logic      por_reset,
    input wire logic      external_reset_pin_n,
    input wire logic      other_reset,
    input wire logic      any_interrupt,
    input wire logic      timer4_event,
    input wire pmc_mode_t mode,
    input wire pmc_byte_t power_control_reg_b,
    input wire logic      core_clock_en,
    input wire pmc_byte_t periph_clock_en,
    input wire logic      timer34_slow_clock_en,
    input wire logic      ssu_clock_en,
    input wire logic      fast_oscillator_a_en,
    input wire logic      fast_oscillator_b_en,
    input wire logic      regulator_low_bias,
    input wire logic      core_regulator_en,
    input wire logic      internal_power_en,
    input wire logic      pin_hold,
    input wire logic      wake_pulse
);
    logic sleep;
    logic off;
    assign sleep = mode inside {PMC_SUSPEND, PMC_SNOOZE};
    assign off = mode inside {PMC_STOP, PMC_SHUTDOWN};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    core_clock_a: assert property (core_clock_en == (mode == PMC_NORMAL)) else $error("core clock wrong");
    periph_gate_a: assert property (!(mode inside {PMC_NORMAL, PMC_IDLE}) |-> periph_clock_en == 8'h00)
        else $error("peripheral clock not gated");
    osc_stop_a: assert property (sleep |-> !fast_oscillator_a_en && !fast_oscillator_b_en)
        else $error("fast oscillator running asleep");
    low_bias_a: assert property (regulator_low_bias == (mode == PMC_SNOOZE)) else $error("bias wrong");
    slow_timer_a: assert property (sleep |-> timer34_slow_clock_en && ssu_clock_en)
        else $error("slow timer or serial clock off asleep");
    power_hold_a: assert property (pin_hold == off && internal_power_en == !off)
        else $error("hold or power net wrong");
    core_reg_a: assert property (core_regulator_en == (mode != PMC_SHUTDOWN)) else $error("core regulator wrong");
    sleep_wake_a: assert property (sleep && timer4_event |=>
        mode == PMC_NORMAL && power_control_reg_b == 8'h00 && wake_pulse ##1 !wake_pulse)
        else $error("no wake from sleep");
    idle_wake_a: assert property (mode == PMC_IDLE && any_interrupt |=> mode == PMC_NORMAL)
        else $error("no wake from idle");
    stop_exit_a: assert property (mode == PMC_STOP && other_reset |=> mode == PMC_NORMAL)
        else $error("stop not ended by reset");
    shut_keep_a: assert property (mode == PMC_SHUTDOWN && other_reset && !por_reset && external_reset_pin_n
        && $past(external_reset_pin_n) && $past(external_reset_pin_n, 2) |=> mode == PMC_SHUTDOWN)
        else $error("shutdown left on wrong reset");
endmodule : pmc_power_mode_controller_checker
bind pmc_power_mode_controller pmc_power_mode_controller_checker i_checker (.clock, .rst_b, .por_reset,
    .external_reset_pin_n, .other_reset, .any_interrupt, .timer4_event, .mode, .power_control_reg_b,
    .core_clock_en, .periph_clock_en, .timer34_slow_clock_en, .ssu_clock_en, .fast_oscillator_a_en,
    .fast_oscillator_b_en, .regulator_low_bias, .core_regulator_en, .internal_power_en, .pin_hold, .wake_pulse);
`default_nettype wire

// ===== test/pmc_power_mode_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module pmc_power_mode_controller_tb;
    import pmc_pkg::*;
    logic clock = 1'h0, rst_b = 1'h0, por_reset = 1'h0, external_reset_pin_n = 1'h1, other_reset = 1'h0;
    logic pca_wr = 1'h0, pcb_wr = 1'h0, reg_wr = 1'h0, vreg5_enable = 1'h0, any_interrupt = 1'h0;
    logic timer4_event = 1'h0, ssu_byte_received = 1'h0, two_wire_slave_activity = 1'h0;
    logic port_match_event = 1'h0, comparator0_out = 1'h1;
    pmc_byte_t pca_wdata = 8'h00, pcb_wdata = 8'h00, reg_wdata = 8'h00, periph_enable = 8'h00;
    logic [3:0] analog_enable = 4'h0, analog_on;
    pmc_byte_t power_control_reg_a, power_control_reg_b, regulator_control_reg, periph_clock_en;
    pmc_mode_t mode;
    logic core_clock_en, timer34_slow_clock_en, ssu_clock_en, fast_oscillator_a_en, fast_oscillator_b_en;
    logic regulator_low_bias, core_regulator_en, vreg5_on, internal_power_en, pin_hold, wake_pulse;
    int fail_count = 0, checked = 0;
    pmc_power_mode_controller i_pmc_power_mode_controller (.*);
    always #25 clock = ~clock;
    task automatic nf(int n);
        repeat (n) @(negedge clock);
    endtask : nf
    task automatic wr(int which, pmc_byte_t d);
        @(negedge clock);
        pca_wr = (which == 0);
        pcb_wr = (which == 1);
        reg_wr = (which == 2);
        pca_wdata = d;
        pcb_wdata = d;
        reg_wdata = d;
        @(negedge clock);
        {pca_wr, pcb_wr, reg_wr} = 3'h0;
    endtask : wr
    task automatic t_idle();
        periph_enable = 8'h5a;
        wr(0, 8'h01);
        `CHK("idle mode", PMC_IDLE, mode)
        `CHK("periph clk", 8'h5a, periph_clock_en)
        any_interrupt = 1'h1;
        nf(1);
        any_interrupt = 1'h0;
        `CHK("idle wake", PMC_NORMAL, mode)
        `CHK("idle clear", 8'h00, power_control_reg_a)
        periph_enable = 8'h00;
        nf(3);
        `CHK("periph off", 8'h00, periph_clock_en)
        $display("test idle done");
    endtask : t_idle
    task automatic t_sleep(int snz, int src);
        pmc_mode_t exp;
        exp = snz ? PMC_SNOOZE : PMC_SUSPEND;
        `CHK("fast osc a", 1'h1, fast_oscillator_a_en)
        wr(1, snz ? 8'h02 : 8'h01);
        `CHK("sleep mode", exp, mode)
        `CHK("osc a stop", 1'h0, fast_oscillator_a_en)
        `CHK("osc b stop", 1'h0, fast_oscillator_b_en)
        `CHK("low bias", snz[0], regulator_low_bias)
        `CHK("ssu clk", 1'h1, ssu_clock_en)
        // Stop request and plain interrupt must both be ignored here
        wr(0, 8'h02);
        any_interrupt = 1'h1;
        nf(1);
        any_interrupt = 1'h0;
        `CHK("held", exp, mode)
        `CHK("stop refused", 8'h00, power_control_reg_a)
        timer4_event = (src == 0);
        ssu_byte_received = (src == 1);
        two_wire_slave_activity = (src == 2);
        port_match_event = (src == 3);
        comparator0_out = (src != 4);
        nf(1);
        {timer4_event, ssu_byte_received, two_wire_slave_activity, port_match_event} = 4'h0;
        repeat (6) if (mode !== PMC_NORMAL) nf(1);
        `CHK("woke", PMC_NORMAL, mode)
        `CHK("bit clear", 8'h00, power_control_reg_b)
        `CHK("wake pulse", 1'h1, wake_pulse)
        nf(1);
        `CHK("pulse ends", 1'h0, wake_pulse)
        comparator0_out = 1'h1;
        nf(4);
        $display("test sleep %0d source %0d done", snz, src);
    endtask : t_sleep
    task automatic t_off(int shd, int how);
        vreg5_enable = (how != 1);
        wr(2, shd ? 8'h01 : 8'h00);
        wr(0, 8'h02);
        `CHK("off mode", shd ? PMC_SHUTDOWN : PMC_STOP, mode)
        `CHK("core reg", !shd, core_regulator_en)
        `CHK("select bit", shd ? 8'h01 : 8'h00, regulator_control_reg)
        `CHK("vreg5", how != 1, vreg5_on)
        `CHK("pins held", 1'h1, pin_hold)
        `CHK("analog off", 4'h0, analog_on)
        vreg5_enable = (how == 1);
        nf(1);
        `CHK("vreg5 held", how != 1, vreg5_on)
        if (shd) begin
            other_reset = 1'h1;
            nf(1);
            other_reset = 1'h0;
            nf(2);
            `CHK("shut kept", PMC_SHUTDOWN, mode)
        end
        por_reset = (how == 1);
        other_reset = (how == 0);
        external_reset_pin_n = (how != 2);
        nf(1);
        {por_reset, other_reset, external_reset_pin_n} = 3'h1;
        repeat (6) if (mode !== PMC_NORMAL) nf(1);
        `CHK("reset wake", PMC_NORMAL, mode)
        `CHK("pins free", 1'h0, pin_hold)
        nf(3);
        $display("test off %0d via %0d done", shd, how);
    endtask : t_off
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        nf(10);
        rst_b = 1'h1;
        analog_enable = 4'ha;
        vreg5_enable = 1'h1;
        nf(3);
        `CHK("analog on", 4'ha, analog_on)
        analog_enable = 4'h0;
        nf(3);
        `CHK("analog sw off", 4'h0, analog_on)
        analog_enable = 4'ha;
        t_idle();
        for (int s = 0; s < 2; s++) for (int w = 0; w < 5; w++) t_sleep(s, w);
        t_off(0, 0);
        t_off(1, 1);
        t_off(1, 2);
        final_report();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #(50 * 3000);
        fail_count++;
        final_report();
    end
endmodule : pmc_power_mode_controller_tb
`default_nettype wire
